/* sdram_cmd_defs.vh */
// Constants for the synchronous DRAM command and state logic.
`ifndef SDRAM_CMD_DEFS_VH
`define SDRAM_CMD_DEFS_VH
`define CLK_PERIOD_NS 8
`define PRECHARGE_TIME_NS 20
`define ACTIVATE_TO_ACCESS_TIME_NS 20
`define MODE_LOAD_TIME_CYC 2
`define REFRESH_CYCLE_NS 70
`define SELF_REFRESH_EXIT_NS 70
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_W 11
`define COL_W 8
`define AUTO_CLOSE_POS 10
`define BURST_LEN_DEF 8
`define MODE_RESET 11'h000
`define FIFO_DEPTH_DEF 16
`endif

/* word_fifo.v */
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module word_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written without reset; only pointers and count need a defined value.
  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Head word is shown combinationally from the array.
  always @* begin
    out_data = mem[rd_q];
  end

  // Pointers and count; a flush empties the queue.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // word_fifo

/* bank_tracker.v */
// Per-bank state and timing counter for one DRAM bank.
`timescale 1ns/1ns
`include "sdram_cmd_defs.vh"
module bank_tracker #(
  parameter T_PRE = 3,
  parameter T_ACT = 3
) (
  input wire clock,
  input wire rst_n,
  input wire hold,
  input wire do_activate,
  input wire do_close,
  input wire do_access,
  input wire access_auto,
  input wire burst_done,
  output wire is_idle,
  output wire is_active,
  output wire is_busy,
  output reg [4:0] state_q
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_ACTING = 5'b00010;
  localparam ST_ACTIVE = 5'b00100;
  localparam ST_AUTOPRE = 5'b01000;
  localparam ST_PRECH = 5'b10000;
  reg [7:0] cnt_q;

  assign is_idle = state_q[0];
  assign is_active = state_q[2];
  assign is_busy = state_q[1] | state_q[3] | state_q[4];

  // State walk; while hold is high the clock is treated as gated.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
    end else if (!hold) begin
      case (state_q)
        ST_IDLE: begin
          if (do_activate) begin
            state_q <= ST_ACTING;
            cnt_q <= T_ACT[7:0];
          end
        end
        ST_ACTING: begin
          if (cnt_q <= 8'h01) begin
            state_q <= ST_ACTIVE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_ACTIVE: begin
          if (do_close) begin
            state_q <= ST_PRECH;
            cnt_q <= T_PRE[7:0];
          end else if (do_access && access_auto) begin
            state_q <= ST_AUTOPRE;
          end
        end
        ST_AUTOPRE: begin
          if (burst_done) begin
            state_q <= ST_PRECH;
            cnt_q <= T_PRE[7:0];
          end
        end
        ST_PRECH: begin
          if (cnt_q <= 8'h01) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // bank_tracker

/* sdram_command_state_logic.v */
// Command decoder, clock-gate tracking and bank state logic for a four-bank SDRAM.
`timescale 1ns/1ns
`include "sdram_cmd_defs.vh"
module sdram_command_state_logic #(
  parameter BURST_LEN = `BURST_LEN_DEF,
  parameter FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  input wire clock,
  input wire rst_n,
  input wire clock_gate,
  input wire chip_select_n,
  input wire row_strobe_n,
  input wire column_strobe_n,
  input wire write_strobe_n,
  input wire [1:0] bank_select,
  input wire [10:0] addr,
  input wire [3:0] byte_mask,
  input wire [31:0] dq_in,
  output reg [31:0] dq_out,
  output reg [3:0] dq_oe,
  output wire wr_valid,
  input wire wr_ready,
  output wire [35:0] wr_word,
  output reg [`ROW_W-1:0] refresh_row_q,
  output reg [10:0] mode_q,
  output reg [`ROW_W-1:0] open_row_q,
  output reg [`COL_W-1:0] column_q,
  output reg illegal_q,
  output reg [2:0] power_mode_q
);
  localparam T_PRE = `NS_TO_CYC(`PRECHARGE_TIME_NS);
  localparam T_ACT = `NS_TO_CYC(`ACTIVATE_TO_ACCESS_TIME_NS);
  localparam T_RC = `NS_TO_CYC(`REFRESH_CYCLE_NS);
  localparam T_XSR = `NS_TO_CYC(`SELF_REFRESH_EXIT_NS);
  localparam T_MRD = `MODE_LOAD_TIME_CYC;
  localparam PM_NONE = 3'b000;
  localparam PM_PDOWN = 3'b001;
  localparam PM_SELF = 3'b010;
  localparam PM_SUSP = 3'b100;
  localparam B_NONE = 3'b001;
  localparam B_READ = 3'b010;
  localparam B_WRITE = 3'b100;

  reg gate_prev_q;
  reg [2:0] burst_q;
  reg [1:0] burst_bank_q;
  reg [7:0] burst_cnt_q;
  reg [7:0] busy_cnt_q;
  reg [3:0] mask_d1_q;
  reg [3:0] mask_d2_q;
  reg rd_d1_q;
  reg rd_d2_q;
  wire cmd_sel;
  wire is_nop;
  wire is_act;
  wire is_rd;
  wire is_wr;
  wire is_bst;
  wire is_pre;
  wire is_ref;
  wire is_mrs;
  wire gate_fall;
  wire gate_rise;
  wire all_idle;
  wire live;
  wire [3:0] bank_idle;
  wire [3:0] bank_active;
  wire [3:0] bank_busy;
  wire [3:0] bank_hit;
  wire [3:0] autopre_done;
  wire cmd_busy;
  wire burst_end;

  // Command decode from the strobes while chip select is low.
  assign cmd_sel = !chip_select_n;
  assign is_nop = chip_select_n | (row_strobe_n & column_strobe_n & write_strobe_n);
  assign is_act = cmd_sel & !row_strobe_n & column_strobe_n & write_strobe_n;
  assign is_rd = cmd_sel & row_strobe_n & !column_strobe_n & write_strobe_n;
  assign is_wr = cmd_sel & row_strobe_n & !column_strobe_n & !write_strobe_n;
  assign is_bst = cmd_sel & row_strobe_n & column_strobe_n & !write_strobe_n;
  assign is_pre = cmd_sel & !row_strobe_n & column_strobe_n & !write_strobe_n;
  assign is_ref = cmd_sel & !row_strobe_n & !column_strobe_n & write_strobe_n;
  assign is_mrs = cmd_sel & !row_strobe_n & !column_strobe_n & !write_strobe_n;

  // Gate edges are seen by comparing this edge's sample with the last one.
  assign gate_fall = gate_prev_q & !clock_gate;
  assign gate_rise = !gate_prev_q & clock_gate;
  assign all_idle = &bank_idle;
  assign cmd_busy = (busy_cnt_q != 8'h00);
  // Commands count only on a live edge with no timed all-bank operation running.
  assign live = gate_prev_q & clock_gate & !cmd_busy & (power_mode_q == PM_NONE);
  assign burst_end = (burst_q != B_NONE) & (burst_cnt_q <= 8'h01);

  // One tracker per bank; any power mode other than PM_NONE freezes every bank.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
      assign bank_hit[gi] = (bank_select == gi);
      assign autopre_done[gi] = burst_end & (burst_bank_q == gi);
      bank_tracker #(
        .T_PRE(T_PRE),
        .T_ACT(T_ACT)
      ) u_bank (
        .clock(clock),
        .rst_n(rst_n),
        .hold(power_mode_q != PM_NONE),
        .do_activate(live & is_act & bank_hit[gi]),
        .do_close(live & is_pre & (addr[`AUTO_CLOSE_POS] | bank_hit[gi])),
        .do_access(live & (is_rd | is_wr) & bank_hit[gi]),
        .access_auto(addr[`AUTO_CLOSE_POS]),
        .burst_done(autopre_done[gi]),
        .is_idle(bank_idle[gi]),
        .is_active(bank_active[gi]),
        .is_busy(bank_busy[gi]),
        .state_q()
      );
    end
  endgenerate

  // Power modes entered and left on gate transitions.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gate_prev_q <= 1'b1;
      power_mode_q <= PM_NONE;
    end else begin
      gate_prev_q <= clock_gate;
      case (power_mode_q)
        PM_NONE: begin
          if (gate_fall && burst_q != B_NONE) begin
            power_mode_q <= PM_SUSP;
          end else if (gate_fall && all_idle && is_ref) begin
            power_mode_q <= PM_SELF;
          end else if (gate_fall && all_idle && is_nop) begin
            power_mode_q <= PM_PDOWN;
          end
        end
        PM_PDOWN: begin
          if (gate_rise && is_nop) begin
            power_mode_q <= PM_NONE;
          end
        end
        PM_SELF: begin
          if (gate_rise) begin
            power_mode_q <= PM_NONE;
          end
        end
        PM_SUSP: begin
          if (gate_rise) begin
            power_mode_q <= PM_NONE;
          end
        end
        default: begin
          power_mode_q <= PM_NONE;
        end
      endcase
    end
  end

  // Timed lockout for refresh, mode load, precharge-all and self refresh exit.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= 8'h00;
    end else if (power_mode_q == PM_SELF && gate_rise) begin
      busy_cnt_q <= T_XSR[7:0];
    end else if (live && is_ref && all_idle) begin
      busy_cnt_q <= T_RC[7:0];
    end else if (live && is_mrs && all_idle) begin
      busy_cnt_q <= T_MRD[7:0];
    end else if (live && is_pre && addr[`AUTO_CLOSE_POS]) begin
      busy_cnt_q <= T_PRE[7:0];
    end else if (cmd_busy && power_mode_q == PM_NONE) begin
      busy_cnt_q <= busy_cnt_q - 8'h01;
    end
  end

  // Refresh row counter advances on each refresh, and on self refresh idle edges.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refresh_row_q <= {`ROW_W{1'b0}};
    end else if ((live && is_ref && all_idle) || power_mode_q == PM_SELF) begin
      refresh_row_q <= refresh_row_q + 1'b1;
    end
  end

  // Mode, row and column capture, and the illegal-sequence flag.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `MODE_RESET;
      open_row_q <= {`ROW_W{1'b0}};
      column_q <= {`COL_W{1'b0}};
      illegal_q <= 1'b0;
    end else if (live) begin
      if (is_mrs && all_idle) begin
        mode_q <= addr;
      end
      if (is_act && bank_idle[bank_select]) begin
        open_row_q <= addr;
      end
      if ((is_rd || is_wr) && bank_active[bank_select]) begin
        column_q <= addr[`COL_W-1:0];
      end
      // Sticky once set, since no register path exists to clear it.
      if ((is_act && !bank_idle[bank_select]) ||
          ((is_rd || is_wr) && !bank_active[bank_select]) ||
          ((is_ref || is_mrs) && !all_idle) ||
          (is_pre && addr[`AUTO_CLOSE_POS] && |bank_busy) ||
          (is_pre && !addr[`AUTO_CLOSE_POS] && bank_busy[bank_select])) begin
        illegal_q <= 1'b1;
      end
    end else if (cmd_busy && !is_nop && power_mode_q == PM_NONE) begin
      illegal_q <= 1'b1;
    end
  end

  // Burst tracking: new access restarts, terminate or precharge cuts it short.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      burst_q <= B_NONE;
      burst_bank_q <= 2'b00;
      burst_cnt_q <= 8'h00;
    end else if (power_mode_q == PM_NONE && !gate_fall) begin
      if (live && (is_rd || is_wr) && bank_active[bank_select]) begin
        burst_q <= is_wr ? B_WRITE : B_READ;
        burst_bank_q <= bank_select;
        burst_cnt_q <= BURST_LEN[7:0];
      end else if (live && is_bst) begin
        burst_q <= B_NONE;
      end else if (live && is_pre && (addr[`AUTO_CLOSE_POS] || bank_select == burst_bank_q)) begin
        burst_q <= B_NONE;
      end else if (burst_end) begin
        burst_q <= B_NONE;
      end else if (burst_q != B_NONE) begin
        burst_cnt_q <= burst_cnt_q - 8'h01;
      end
    end
  end

  // Read mask pipeline, two clocks deep, and the read data drive.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_d1_q <= 4'hf;
      mask_d2_q <= 4'hf;
      rd_d1_q <= 1'b0;
      rd_d2_q <= 1'b0;
      dq_oe <= 4'h0;
      dq_out <= 32'h00000000;
    end else if (power_mode_q != PM_SUSP) begin
      mask_d1_q <= byte_mask;
      mask_d2_q <= mask_d1_q;
      rd_d1_q <= (burst_q == B_READ);
      rd_d2_q <= rd_d1_q;
      dq_oe <= {4{rd_d2_q}} & ~mask_d2_q;
      dq_out <= {refresh_row_q[7:0], column_q, mode_q[7:0], open_row_q[7:0]};
    end
  end

  // Write words go to the FIFO with their mask from the same edge stored beside them.
  // The pins cannot stall, so words offered to a full queue are dropped.
  word_fifo #(
    .WIDTH(36),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(1'b0),
    .in_valid((burst_q == B_WRITE) && power_mode_q == PM_NONE && !gate_fall),
    .in_ready(),
    .in_data({byte_mask, dq_in}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );
endmodule // sdram_command_state_logic

/* sdram_chk.sv */
// Checker for command decoding and clock-gate states of the SDRAM logic.
`timescale 1ns/1ns
module sdram_chk (
  input wire clock,
  input wire rst_n,
  input wire clock_gate,
  input wire chip_select_n,
  input wire row_strobe_n,
  input wire column_strobe_n,
  input wire write_strobe_n,
  input wire [10:0] addr,
  input wire [3:0] byte_mask,
  input wire [3:0] dq_oe,
  input wire [10:0] mode_q,
  input wire [10:0] open_row_q,
  input wire [7:0] column_q,
  input wire illegal_q,
  input wire [2:0] power_mode_q
);
  wire [3:0] cmd = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A command only counts with the gate high now and before, in normal mode.
  sequence taken_s(ok);
    ok && clock_gate && $past(clock_gate) && power_mode_q == 3'b000;
  endsequence
  // A refused command raises the flag, so acceptance is seen one cycle later.
  sequence kept_s;
    ##1 !illegal_q;
  endsequence
  mode_load_a: assert property (taken_s(cmd == 4'b0000) ##0 kept_s |-> mode_q == $past(addr))
    else $error("mode register not loaded from address");
  row_open_a: assert property (taken_s(cmd == 4'b0011) ##0 kept_s |-> open_row_q == $past(addr))
    else $error("activated row not taken from address");
  start_column_a: assert property (taken_s(cmd[3:1] == 3'b010) ##0 kept_s
    |-> column_q == $past(addr[7:0]))
    else $error("start column not taken from low address bits");
  inhibit_keep_a: assert property (chip_select_n |=> $stable(mode_q) && $stable(open_row_q))
    else $error("state changed while chip select was high");
  illegal_sticky_a: assert property (illegal_q |=> illegal_q)
    else $error("illegal flag cleared without reset");
  power_onehot_a: assert property ($onehot0(power_mode_q))
    else $error("more than one power mode at once");
  gate_hold_a: assert property (power_mode_q != 3'b000 && !clock_gate
    |=> power_mode_q == $past(power_mode_q))
    else $error("power mode left while gate stayed low");
  pd_exit_a: assert property (power_mode_q == 3'b001 && clock_gate && (cmd[3] || cmd == 4'b0111)
    |=> power_mode_q == 3'b000)
    else $error("power-down not left on gate rise");
  suspend_exit_a: assert property (power_mode_q == 3'b100 && clock_gate
    |=> power_mode_q == 3'b000)
    else $error("clock suspend not left on gate rise");
  mask_read_a: assert property ((dq_oe & $past(byte_mask, 3)) == 4'h0)
    else $error("masked read lane driven");
endmodule // sdram_chk

bind sdram_command_state_logic sdram_chk chk (.clock(clock), .rst_n(rst_n),
  .clock_gate(clock_gate), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr),
  .byte_mask(byte_mask), .dq_oe(dq_oe), .mode_q(mode_q), .open_row_q(open_row_q),
  .column_q(column_q), .illegal_q(illegal_q), .power_mode_q(power_mode_q));

/* sdram_ctrl_model.sv */
// Memory controller model that drives the command pins of the SDRAM logic.
`timescale 1ns/1ns
`include "sdram_cmd_defs.vh"
module sdram_ctrl_model (
  input wire clock,
  output reg clock_gate,
  output reg [3:0] cmd_n,
  output reg [1:0] bank_select,
  output reg [10:0] addr,
  output reg [3:0] byte_mask,
  output reg [31:0] dq_in
);
  // Timing figures held as cycle counts for this clock.
  localparam integer T_PRE = `NS_TO_CYC(`PRECHARGE_TIME_NS);
  localparam integer T_ACT = `NS_TO_CYC(`ACTIVATE_TO_ACCESS_TIME_NS);
  localparam integer T_XSR = `NS_TO_CYC(`SELF_REFRESH_EXIT_NS);
  initial begin
    clock_gate = 1'b1;
    cmd_n = 4'b0111;
    bank_select = 2'h0;
    addr = 11'h000;
    byte_mask = 4'h0;
    dq_in = 32'h0;
  end
  // Data counts up every cycle, so the low byte lane never looks steady.
  always @(posedge clock) begin
    dq_in <= #1 dq_in + 32'h1;
  end
  // One command for one edge, then a no-operation; callers wait out the
  // lockouts with idle, and only send refresh or mode loads to idle banks.
  task go(input [3:0] c, input [1:0] b, input [10:0] a, input g);
    begin
      @(posedge clock);
      #1;
      cmd_n = c;
      bank_select = b;
      addr = a;
      clock_gate = g;
      @(posedge clock);
      #1;
      cmd_n = 4'b0111;
    end
  endtask
  // No-operation cycles, ending just after an edge like go.
  task idle(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
endmodule // sdram_ctrl_model

/* tb.sv */
// Self-checking bench for the SDRAM command and state logic.
`timescale 1ns/1ns
module tb;
  localparam [3:0] NOP = 4'b0111, ACT = 4'b0011, RD = 4'b0101, WR = 4'b0100, BT = 4'b0110;
  localparam [3:0] PRE = 4'b0010, REF = 4'b0001, LMR = 4'b0000, INH = 4'b1000;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg wr_ready = 1'b0;
  wire clock_gate, wr_valid, illegal_q;
  wire [3:0] cmd_n, byte_mask, dq_oe;
  wire [1:0] bank_select;
  wire [10:0] addr, refresh_row_q, mode_q, open_row_q;
  wire [31:0] dq_in, dq_out;
  wire [35:0] wr_word;
  wire [7:0] column_q;
  wire [2:0] power_mode_q;
  reg [35:0] w0, w1;
  reg [10:0] r;
  integer i;
  integer n_fail = 0;
  integer total_checks = 0;
  always #4 clock = ~clock;
  sdram_ctrl_model ctl (.clock(clock), .clock_gate(clock_gate), .cmd_n(cmd_n),
    .bank_select(bank_select), .addr(addr), .byte_mask(byte_mask), .dq_in(dq_in));
  sdram_command_state_logic dut (.clock(clock), .rst_n(rst_n), .clock_gate(clock_gate),
    .chip_select_n(cmd_n[3]), .row_strobe_n(cmd_n[2]), .column_strobe_n(cmd_n[1]),
    .write_strobe_n(cmd_n[0]), .bank_select(bank_select), .addr(addr),
    .byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .refresh_row_q(refresh_row_q), .mode_q(mode_q), .open_row_q(open_row_q),
    .column_q(column_q), .illegal_q(illegal_q), .power_mode_q(power_mode_q));
  task close_out;
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [35:0] got, input [35:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // A wait that ran out of cycles ends the run at once.
  task bound(input integer n, input integer lim);
    begin
      if (n >= lim) begin
        n_fail = n_fail + 1;
        close_out;
      end
    end
  endtask
  task t_mode;
    begin
      ctl.go(LMR, 2'h0, 11'h2a5, 1'b1);
      chk(mode_q, 11'h2a5);
      ctl.idle(2);
      ctl.go(INH, 2'h0, 11'h15a, 1'b1);
      chk(mode_q, 11'h2a5);
    end
  endtask
  task t_read;
    begin
      ctl.byte_mask = 4'h5;
      ctl.go(ACT, 2'h0, 11'h5a3, 1'b1);
      chk(open_row_q, 11'h5a3);
      ctl.idle(ctl.T_ACT);
      ctl.go(RD, 2'h0, 11'h03c, 1'b1);
      chk(column_q, 8'h3c);
      i = 0;
      while (dq_oe === 4'h0 && i < 10) begin
        ctl.idle(1);
        i = i + 1;
      end
      bound(i, 10);
      chk(dq_oe, 4'ha);
      chk(dq_out, 32'h003ca5a3);
      ctl.go(BT, 2'h2, 11'h000, 1'b1);
      ctl.idle(3);
      chk(dq_oe, 4'h0);
      ctl.go(PRE, 2'h0, 11'h000, 1'b1);
      ctl.idle(ctl.T_PRE);
      // A second precharge to the idle bank must not restart its timer.
      ctl.go(PRE, 2'h0, 11'h000, 1'b1);
      ctl.go(ACT, 2'h0, 11'h7ff, 1'b1);
      chk(illegal_q, 1'b0);
      chk(open_row_q, 11'h7ff);
      // An activating bank may not be cut, so precharge-all waits for the row.
      ctl.idle(ctl.T_ACT);
      ctl.go(PRE, 2'h1, 11'h400, 1'b1);
      ctl.idle(ctl.T_PRE);
      ctl.byte_mask = 4'h0;
    end
  endtask
  task t_fifo;
    begin
      ctl.byte_mask = 4'h3;
      ctl.go(ACT, 2'h1, 11'h011, 1'b1);
      ctl.idle(ctl.T_ACT);
      // Three bursts into a stalled queue: the third cannot fit.
      repeat (3) begin
        ctl.go(WR, 2'h1, 11'h000, 1'b1);
        ctl.idle(9);
      end
      chk(wr_valid, 1'b1);
      wr_ready = 1'b1;
      i = 0;
      while (wr_valid === 1'b1 && i < 40) begin
        if (i == 0)
          w0 = wr_word;
        if (i == 1)
          w1 = wr_word;
        ctl.idle(1);
        i = i + 1;
      end
      bound(i, 40);
      chk(i, 16);
      chk(w0[35:32], 4'h3);
      chk(w1[31:0], w0[31:0] + 32'h1);
      ctl.byte_mask = 4'h0;
      ctl.go(PRE, 2'h0, 11'h400, 1'b1);
      ctl.idle(ctl.T_PRE);
      chk(illegal_q, 1'b0);
    end
  endtask
  task t_power;
    begin
      ctl.go(NOP, 2'h0, 11'h000, 1'b0);
      chk(power_mode_q, 3'b001);
      ctl.idle(3);
      chk(power_mode_q, 3'b001);
      ctl.go(NOP, 2'h0, 11'h000, 1'b1);
      chk(power_mode_q, 3'b000);
      ctl.go(REF, 2'h0, 11'h000, 1'b0);
      chk(power_mode_q, 3'b010);
      r = refresh_row_q;
      ctl.idle(4);
      chk(refresh_row_q, r + 11'h4);
      ctl.go(LMR, 2'h0, 11'h0ff, 1'b0);
      chk(mode_q, 11'h2a5);
      ctl.go(NOP, 2'h0, 11'h000, 1'b1);
      ctl.idle(ctl.T_XSR);
      chk(power_mode_q, 3'b000);
      ctl.go(ACT, 2'h2, 11'h100, 1'b1);
      ctl.idle(ctl.T_ACT);
      ctl.go(RD, 2'h2, 11'h000, 1'b1);
      ctl.go(NOP, 2'h0, 11'h000, 1'b0);
      chk(power_mode_q, 3'b100);
      ctl.go(NOP, 2'h0, 11'h000, 1'b1);
      chk(power_mode_q, 3'b000);
      ctl.idle(12);
    end
  endtask
  task t_illegal;
    begin
      ctl.go(RD, 2'h3, 11'h000, 1'b1);
      chk(illegal_q, 1'b1);
      ctl.idle(2);
      chk(illegal_q, 1'b1);
      rst_n = 1'b0;
      ctl.idle(2);
      rst_n = 1'b1;
      chk(illegal_q, 1'b0);
      chk(mode_q, 11'h000);
    end
  endtask
  // Reset covers the first three rising edges, then the scenarios run in turn.
  initial begin
    #21 rst_n = 1'b1;
    ctl.idle(1);
    t_mode;
    t_read;
    t_fifo;
    t_power;
    t_illegal;
    close_out;
  end
endmodule // tb
